//--- logic/smc_pkg.sv
// Purpose: constants and types for the switch mode and channel controller
// Assumes: 50 MHz internal oscillator clock, AHB-Lite register access
// Notes: byte offsets are word aligned; reserved bits read as zero
package smc_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int WDTO_MS = 310;
   localparam int WDTO_CYC = WDTO_MS * (CLK_HZ / 1000);
   localparam int TIN_MS = 250;
   localparam int TIN_CYC = TIN_MS * (CLK_HZ / 1000);
   localparam int WAKE_US = 50;
   localparam int WAKE_CYC = WAKE_US * (CLK_HZ / 1_000_000);
   localparam int PWM_MAX_HZ = 1000;
   localparam int PWM_STEPS = 256;
   localparam int BASE_DIV = CLK_HZ / (PWM_MAX_HZ * PWM_STEPS);
   localparam int CNT_W = 24;
   // register byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_STATE = 6'h04;
   localparam logic [5:0] OFS_PW0 = 6'h08;
   localparam logic [5:0] OFS_PW1 = 6'h0c;
   localparam logic [5:0] OFS_CFG0 = 6'h10;
   localparam logic [5:0] OFS_CFG1 = 6'h14;
   localparam logic [5:0] OFS_OC0 = 6'h18;
   localparam logic [5:0] OFS_OC1 = 6'h1c;
   localparam logic [5:0] OFS_FLT0 = 6'h20;
   localparam logic [5:0] OFS_FLT1 = 6'h24;
   // control register bits; bit 15 of any write is the toggle bit
   localparam int CTL_WATCHDOG_DISABLE_BIT = 0;
   localparam int CTL_SF_EN = 1;
   localparam int CTL_OV_SEL = 2;
   localparam int WD_TOGGLE_BIT = 15;
   // channel config fields
   localparam int CFG_ON = 0;
   localparam int CFG_MOD_EN = 1;
   localparam int CFG_CLK_INT = 2;
   localparam int CFG_PRE = 3;
   localparam int CFG_DIR_DIS = 5;
   localparam int CFG_DELAY = 6;
   localparam int CFG_SLEW = 8;
   // channel fault register bits
   localparam int FLT_OC = 0;
   localparam int FLT_OT = 1;
   localparam int FLT_SC = 2;
   // global state register fields
   localparam int ST_DRIVE = 0;
   localparam int ST_MODE = 2;
   localparam int ST_NM = 4;
   localparam int ST_WDTO = 5;
   localparam int ST_READY = 6;
   localparam int ST_UV = 7;
   localparam int ST_OV = 8;
   localparam int ST_ACT = 9;
   localparam int ST_CHFLT = 11;
   // reset values
   localparam logic [2:0] CTL_RST = 3'h0;
   localparam logic [7:0] PW_RST = 8'h00;
   localparam logic [9:0] CFG_RST = 10'h000;
   localparam logic [7:0] OC_RST = 8'h00;

   typedef enum logic [1:0] {
      SMC_SLEEP = 2'b00,
      SMC_NORMAL = 2'b01,
      SMC_FAILSAFE = 2'b10,
      SMC_FAULT = 2'b11
   } smc_mode_t;
endpackage

//--- logic/smc_channel.sv
// Purpose: one channel modulator and drive target
// Assumes: base tick and external edge are one-cycle pulses
// Notes: prescaler divides the step rate by 1, 2, 4 or 8
`timescale 1ns/1ns
`default_nettype none
module smc_channel #(
   parameter int DUTY_W = 8,
   parameter int PRE_W = 2
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic base_tick_i,
   input wire logic ext_edge_i,
   input wire logic clk_int_i,
   input wire logic [PRE_W-1:0] presc_i,
   input wire logic [DUTY_W-1:0] duty_i,
   input wire logic mod_en_i,
   input wire logic on_i,
   input wire logic dir_dis_i,
   input wire logic din_i,
   output logic hson_o
);
   localparam int PC_W = (1 << PRE_W) - 1;
   typedef struct packed {
      logic [PC_W-1:0] pre_cnt;
      logic [DUTY_W-1:0] step;
      logic hson;
   } smc_ch_state_t;
   smc_ch_state_t s_q, s_d;
   logic tick;
   logic [PC_W-1:0] pre_lim;
   logic duty_on;

   assign tick = clk_int_i ? base_tick_i : ext_edge_i;
   assign pre_lim = (PC_W'(1) << presc_i) - PC_W'(1);
   assign duty_on = s_q.step < duty_i;

   always_comb begin
      s_d = s_q;
      if (tick) begin
         if (s_q.pre_cnt >= pre_lim) begin
            s_d.pre_cnt = '0;
            s_d.step = s_q.step + DUTY_W'(1);
         end else begin
            s_d.pre_cnt = s_q.pre_cnt + PC_W'(1);
         end
      end
      s_d.hson = (din_i & ~dir_dis_i) | (on_i & duty_on & mod_en_i) |
                 (on_i & ~mod_en_i);
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hson_o = s_q.hson;

   AST_FORCED_ON: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (on_i && !mod_en_i) |=> hson_o)
      else $error("on bit without modulator did not drive");
   AST_ZERO_DUTY: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (on_i && mod_en_i && duty_i == '0 && (!din_i || dir_dis_i))
      |=> !hson_o)
      else $error("zero duty still drove the channel");
endmodule // smc_channel
`default_nettype wire

//--- logic/smc_ctrl.sv
// Purpose: mode controller, watchdog, activity timers, registers
// Assumes: single 50 MHz clock, inputs synchronous to it
// Notes: zero wait state AHB-Lite slave, always OKAY
`timescale 1ns/1ns
`default_nettype none
module smc_ctrl
   import smc_pkg::*;
#(
   parameter int WD_CYCLES = smc_pkg::WDTO_CYC,
   parameter int IN_CYCLES = smc_pkg::TIN_CYC,
   parameter int CH = 2
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic [31:0] hrdata_o,
   output logic hresp_o,
   input wire logic active_low_reset_pin_i,
   input wire logic [CH-1:0] dir_in_i,
   input wire logic ext_clk_i,
   input wire logic [CH-1:0] overcurrent_fault_i,
   input wire logic [CH-1:0] overtemperature_fault_i,
   input wire logic [CH-1:0] severe_short_fault_i,
   input wire logic undervoltage_fault_i,
   input wire logic overvoltage_fault_i,
   input wire logic logic_supply_fail_i,
   output logic [CH-1:0] drive_target_o,
   output logic [1:0] mode_o,
   output logic normal_mode_flag_o,
   output logic ready_o,
   output logic failsafe_output_pin_o,
   output logic failsafe_output_pin_oe_o
);
   import smc_pkg::*;

   typedef struct packed {
      smc_mode_t mode;
      logic nm;
      logic ready;
      logic [11:0] rdy_cnt;
      logic fso_oe;
      logic [CH-1:0] drive;
      logic pin_last;
      logic [CH-1:0] din_last;
      logic [CH-1:0] act;
      logic [CH-1:0][CNT_W-1:0] act_cnt;
      logic [CNT_W-1:0] wd_cnt;
      logic wd_to;
      logic wd_last;
      logic wd_arm;
      logic sf_lat;
      logic [2:0] ctl;
      logic [CH-1:0][7:0] pw;
      logic [CH-1:0][9:0] cfg;
      logic [CH-1:0][7:0] oc;
      logic [CH-1:0][2:0] flt;
      logic uv_st;
      logic ov_st;
      logic [7:0] base_cnt;
      logic base_tick;
      logic ext_last;
      logic ext_edge;
      logic hready;
      logic [31:0] hrdata;
      logic wr_pend;
      logic [5:0] wr_addr;
   } smc_state_t;

   smc_state_t s_q, s_d;
   logic pin;
   logic awake;
   logic fs_c;
   logic flt_c;
   logic addr_ph;
   logic rd_ph;
   logic cfg_clr;
   logic wr_ok;
   logic wr_toggle;
   logic [CH-1:0] hson;
   logic [CH-1:0][2:0] flt_cause;
   logic [31:0] rd_val;

   assign pin = active_low_reset_pin_i;
   assign awake = pin | (|s_q.act);
   assign fs_c = (logic_supply_fail_i & (s_q.ctl[CTL_SF_EN] | s_q.sf_lat)) |
                 (s_q.wd_to & ~s_q.ctl[CTL_WATCHDOG_DISABLE_BIT]);
   assign flt_c = (|overcurrent_fault_i) | (|overtemperature_fault_i) |
                  (|severe_short_fault_i) | undervoltage_fault_i |
                  (overvoltage_fault_i & s_q.ctl[CTL_OV_SEL]);
   assign addr_ph = hsel_i & htrans_i[1] & hready_i;
   assign rd_ph = addr_ph & ~hwrite_i;
   // registers held at default in sleep, on a fail-safe cause, or while reset pin low
   assign cfg_clr = (s_q.mode == SMC_SLEEP) | fs_c | ~pin;
   assign wr_ok = s_q.wr_pend & ~cfg_clr & s_q.ready &
                  (s_q.mode == SMC_NORMAL);
   assign wr_toggle = hwdata_i[WD_TOGGLE_BIT];

   genvar g;
   generate
      for (g = 0; g < CH; g++) begin : g_ch
         assign flt_cause[g] = {severe_short_fault_i[g],
                                overtemperature_fault_i[g],
                                overcurrent_fault_i[g]};
         smc_channel #(
            .DUTY_W(8),
            .PRE_W(2)
         ) u_ch (
            .mclk_i(mclk_i),
            .sys_rst_i(sys_rst_i),
            .base_tick_i(s_q.base_tick),
            .ext_edge_i(s_q.ext_edge),
            .clk_int_i(s_q.cfg[g][CFG_CLK_INT]),
            .presc_i(s_q.cfg[g][CFG_PRE +: 2]),
            .duty_i(s_q.pw[g]),
            .mod_en_i(s_q.cfg[g][CFG_MOD_EN]),
            .on_i(s_q.cfg[g][CFG_ON]),
            .dir_dis_i(s_q.cfg[g][CFG_DIR_DIS]),
            .din_i(dir_in_i[g]),
            .hson_o(hson[g])
         );
      end
   endgenerate

   always_comb begin
      rd_val = '0;
      case (haddr_i[5:0])
         OFS_CTRL: begin
            rd_val[2:0] = s_q.ctl;
            rd_val[WD_TOGGLE_BIT] = s_q.wd_last;
         end
         OFS_STATE: begin
            rd_val[ST_DRIVE +: 2] = s_q.drive;
            rd_val[ST_MODE +: 2] = s_q.mode;
            rd_val[ST_NM] = s_q.nm;
            rd_val[ST_WDTO] = s_q.wd_to;
            rd_val[ST_READY] = s_q.ready;
            rd_val[ST_UV] = s_q.uv_st;
            rd_val[ST_OV] = s_q.ov_st;
            rd_val[ST_ACT +: 2] = s_q.act;
            rd_val[ST_CHFLT] = |s_q.flt[0];
            rd_val[ST_CHFLT + 1] = |s_q.flt[1];
         end
         OFS_PW0: rd_val[7:0] = s_q.pw[0];
         OFS_PW1: rd_val[7:0] = s_q.pw[1];
         OFS_CFG0: rd_val[9:0] = s_q.cfg[0];
         OFS_CFG1: rd_val[9:0] = s_q.cfg[1];
         OFS_OC0: rd_val[7:0] = s_q.oc[0];
         OFS_OC1: rd_val[7:0] = s_q.oc[1];
         OFS_FLT0: rd_val[2:0] = s_q.flt[0];
         OFS_FLT1: rd_val[2:0] = s_q.flt[1];
         default: rd_val = '0;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.pin_last = pin;
      s_d.din_last = dir_in_i;
      s_d.ext_last = ext_clk_i;
      s_d.ext_edge = ext_clk_i & ~s_q.ext_last;
      // cause held; fail-safe clears its own enable
      s_d.sf_lat = logic_supply_fail_i & (s_q.ctl[CTL_SF_EN] | s_q.sf_lat);
      // base step rate: 256 steps at the 1 kHz ceiling
      if (s_q.base_cnt == 8'(BASE_DIV - 1)) begin
         s_d.base_cnt = '0;
         s_d.base_tick = 1'b1;
      end else begin
         s_d.base_cnt = s_q.base_cnt + 8'h01;
         s_d.base_tick = 1'b0;
      end
      for (int i = 0; i < CH; i++) begin
         if (dir_in_i[i]) begin
            s_d.act[i] = 1'b1;
            s_d.act_cnt[i] = '0;
         end else if (s_q.act[i]) begin
            if (s_q.act_cnt[i] == CNT_W'(IN_CYCLES - 1)) begin
               s_d.act[i] = 1'b0;
               s_d.act_cnt[i] = '0;
            end else begin
               s_d.act_cnt[i] = s_q.act_cnt[i] + CNT_W'(1);
            end
         end
      end
      // watchdog; restarted by reset pin rise
      if (!pin || (pin && !s_q.pin_last)) begin
         s_d.wd_cnt = '0;
         s_d.wd_to = 1'b0;
         s_d.wd_arm = 1'b0;
      end else if (!s_q.wd_to) begin
         if (s_q.wr_pend && wr_toggle != s_q.wd_last) begin
            s_d.wd_cnt = '0;
         end else if (s_q.ctl[CTL_WATCHDOG_DISABLE_BIT]) begin
            s_d.wd_cnt = '0;
         end else if (s_q.wd_cnt == CNT_W'(WD_CYCLES - 1)) begin
            s_d.wd_to = 1'b1;
            s_d.wd_cnt = '0;
         end else begin
            s_d.wd_cnt = s_q.wd_cnt + CNT_W'(1);
         end
      end else begin
         // leaving fail-safe: toggle-high word, then a second in time
         if (s_q.wr_pend && s_q.wd_arm) begin
            s_d.wd_to = 1'b0;
            s_d.wd_arm = 1'b0;
            s_d.wd_cnt = '0;
         end else if (s_q.wr_pend && wr_toggle) begin
            s_d.wd_arm = 1'b1;
            s_d.wd_cnt = '0;
         end else if (s_q.wd_arm) begin
            if (s_q.wd_cnt == CNT_W'(WD_CYCLES - 1)) begin
               s_d.wd_arm = 1'b0;
            end else begin
               s_d.wd_cnt = s_q.wd_cnt + CNT_W'(1);
            end
         end
      end
      if (s_q.wr_pend) begin
         s_d.wd_last = wr_toggle;
      end
      if (cfg_clr) begin
         s_d.ctl = CTL_RST;
         s_d.pw = {CH{PW_RST}};
         s_d.cfg = {CH{CFG_RST}};
         s_d.oc = {CH{OC_RST}};
      end else if (wr_ok) begin
         case (s_q.wr_addr)
            OFS_CTRL: s_d.ctl = hwdata_i[2:0];
            OFS_PW0: s_d.pw[0] = hwdata_i[7:0];
            OFS_PW1: s_d.pw[1] = hwdata_i[7:0];
            OFS_CFG0: s_d.cfg[0] = hwdata_i[9:0];
            OFS_CFG1: s_d.cfg[1] = hwdata_i[9:0];
            OFS_OC0: s_d.oc[0] = hwdata_i[7:0];
            OFS_OC1: s_d.oc[1] = hwdata_i[7:0];
            default: s_d.ctl = s_q.ctl;
         endcase
      end
      // sticky faults; a live cause beats the read clear
      for (int i = 0; i < CH; i++) begin
         if (rd_ph && haddr_i[5:0] == (i == 0 ? OFS_FLT0 : OFS_FLT1)) begin
            s_d.flt[i] = flt_cause[i];
         end else begin
            s_d.flt[i] = s_q.flt[i] | flt_cause[i];
         end
      end
      if (rd_ph && haddr_i[5:0] == OFS_STATE) begin
         s_d.uv_st = undervoltage_fault_i;
         s_d.ov_st = overvoltage_fault_i;
      end else begin
         s_d.uv_st = s_q.uv_st | undervoltage_fault_i;
         s_d.ov_st = s_q.ov_st | overvoltage_fault_i;
      end
      if (!awake) begin
         s_d.mode = SMC_SLEEP;
      end else if (flt_c) begin
         s_d.mode = SMC_FAULT;
      end else if (fs_c) begin
         s_d.mode = SMC_FAILSAFE;
      end else begin
         s_d.mode = SMC_NORMAL;
      end
      s_d.nm = (s_d.mode == SMC_NORMAL);
      s_d.fso_oe = ~(s_d.mode == SMC_FAILSAFE);
      if (s_d.mode == SMC_SLEEP) begin
         s_d.ready = 1'b0;
         s_d.rdy_cnt = 12'(WAKE_CYC - 1);
      end else if (s_q.rdy_cnt != '0) begin
         s_d.rdy_cnt = s_q.rdy_cnt - 12'h001;
      end else begin
         s_d.ready = 1'b1;
      end
      case (s_q.mode)
         SMC_SLEEP: s_d.drive = '0;
         SMC_FAULT: s_d.drive = '0;
         SMC_FAILSAFE: s_d.drive = dir_in_i;
         // plain input level when reset pin low
         SMC_NORMAL: s_d.drive = pin ? hson : dir_in_i;
         default: s_d.drive = '0;
      endcase
      // bus slave: reads answered in the data phase, no wait states
      s_d.hready = 1'b1;
      s_d.wr_pend = addr_ph & hwrite_i;
      s_d.wr_addr = haddr_i[5:0];
      if (rd_ph) begin
         s_d.hrdata = rd_val;
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
         s_q.hready <= 1'b1;
         s_q.fso_oe <= 1'b1;
         s_q.rdy_cnt <= 12'(WAKE_CYC - 1);
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout_o = s_q.hready;
   assign hrdata_o = s_q.hrdata;
   assign hresp_o = 1'b0;
   assign drive_target_o = s_q.drive;
   assign mode_o = s_q.mode;
   assign normal_mode_flag_o = s_q.nm;
   assign ready_o = s_q.ready;
   assign failsafe_output_pin_o = 1'b0;
   assign failsafe_output_pin_oe_o = s_q.fso_oe;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   AST_SLEEP_OFF: assert property (
      (s_q.mode == SMC_SLEEP) |=> (drive_target_o == '0))
      else $error("channel driven in sleep mode");
   AST_FAULT_OFF: assert property (
      (s_q.mode == SMC_FAULT) |=> (drive_target_o == '0))
      else $error("channel driven in fault mode");
   AST_FS_DIRECT: assert property (
      (s_q.mode == SMC_FAILSAFE) |=> (drive_target_o == $past(dir_in_i)))
      else $error("fail-safe drive not equal to direct inputs");
   AST_FAULT_ENTRY: assert property (
      (awake && flt_c) |=> (mode_o == 2'b11))
      else $error("fault condition did not enter fault mode");
   AST_NM_FLAG: assert property (
      $rose(normal_mode_flag_o) |-> $past(awake && !fs_c && !flt_c))
      else $error("normal flag rose without its conditions");
   AST_WAKE_CLEAR: assert property (
      (s_q.mode == SMC_SLEEP) |=> (s_q.cfg == '0 && s_q.pw == '0))
      else $error("registers not at default after sleep");
   AST_READY_WAIT: assert property (
      (s_q.mode == SMC_SLEEP && awake) |=> !ready_o [*8])
      else $error("ready before the wake delay");
   AST_WD_FAILSAFE: assert property (
      (s_q.wd_to && !s_q.ctl[CTL_WATCHDOG_DISABLE_BIT] && awake && !flt_c)
      |=> (mode_o == 2'b10) && !failsafe_output_pin_oe_o)
      else $error("watchdog timeout did not enter fail-safe");
   AST_ACT_DROP: assert property (
      (s_q.act[0] && !dir_in_i[0] &&
       s_q.act_cnt[0] == CNT_W'(IN_CYCLES - 1)) |=> !s_q.act[0])
      else $error("activity flag kept after idle time");
endmodule // smc_ctrl
`default_nettype wire

//--- tb/smc_host.sv
// Purpose: host bus model for the register port
// Assumes: one slave, hready fed back from its hreadyout
// Notes: every write carries a fresh toggle bit
`timescale 1ns/1ns
`default_nettype none
module smc_host (
   input wire logic mclk_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_i,
   output logic hsel_o,
   output logic [31:0] haddr_o,
   output logic [1:0] htrans_o,
   output logic hwrite_o,
   output logic [2:0] hsize_o,
   output logic [31:0] hwdata_o
);
   import smc_pkg::*;
   logic tog = 1'b0;
   initial begin
      hsel_o = 1'b0;
      haddr_o = 32'h0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o = 3'h2;
      hwdata_o = 32'h0;
   end
   task automatic xfer(input logic [5:0] a, input logic w,
         input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk_i);
      hsel_o <= 1'b1;
      haddr_o <= {26'h0, a};
      htrans_o <= 2'h2;
      hwrite_o <= w;
      do @(posedge mclk_i); while (hready_i !== 1'b1);
      htrans_o <= 2'h0;
      hwdata_o <= d;
      do @(posedge mclk_i); while (hready_i !== 1'b1);
      q = hrdata_i;
      hsel_o <= 1'b0;
      // released data inverted, never a stale copy
      hwdata_o <= ~d;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] v;
      logic [31:0] q;
      v = d;
      tog = ~tog;
      v[WD_TOGGLE_BIT] = tog;
      xfer(a, 1'b1, v, q);
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] q);
      xfer(a, 1'b0, 32'h0, q);
   endtask
endmodule // smc_host
`default_nettype wire

//--- tb/switch_mode_and_channel_control_tb_top.sv
// Purpose: self-checking bench for the mode and channel controller
// Assumes: shortened watchdog and idle counts
// Notes: expectations queued, compared by a monitor process
`timescale 1ns/1ns
`default_nettype none
module switch_mode_and_channel_control_tb_top;
   import smc_pkg::*;
   localparam int WDC = 200;
   localparam int INC = 100;
   typedef struct {int sel; logic [31:0] v;} smc_exp_t;
   smc_exp_t exp_q[$];
   event chk_ev;
   int error_cnt = 0;
   int checks_done = 0;
   int cnt = 0;
   logic mclk = 1'b0, sys_rst = 1'b1, rst_pin = 1'b0, ext_clk = 1'b0;
   logic uv = 1'b0, ov = 1'b0, lsf = 1'b0;
   logic [1:0] dir_in = 2'h0, oc = 2'h0, ot = 2'h0, sc = 2'h0;
   logic [1:0] drive, mode, htrans;
   logic nm, ready, fs_oe, hready, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata, rd_last, q;
   logic [2:0] hsize;
   logic [11:0] tbl [5] = '{12'hc00, 12'h420, 12'h801, 12'h003, 12'h007};
   string nms [7] = '{"drive", "mode", "nm", "fs_oe", "rdata", "duty",
      "ready"};
   int c;
   logic [1:0] dv;
   initial forever #10 mclk = ~mclk;
   smc_ctrl #(.WD_CYCLES(WDC), .IN_CYCLES(INC), .CH(2)) dut_u (
      .mclk_i(mclk), .sys_rst_i(sys_rst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
      .hrdata_o(hrdata), .hresp_o(), .active_low_reset_pin_i(rst_pin),
      .dir_in_i(dir_in), .ext_clk_i(ext_clk), .overcurrent_fault_i(oc),
      .overtemperature_fault_i(ot), .severe_short_fault_i(sc),
      .undervoltage_fault_i(uv), .overvoltage_fault_i(ov),
      .logic_supply_fail_i(lsf), .drive_target_o(drive), .mode_o(mode),
      .normal_mode_flag_o(nm), .ready_o(ready),
      .failsafe_output_pin_o(), .failsafe_output_pin_oe_o(fs_oe));
   smc_host host_u (.mclk_i(mclk), .hready_i(hready), .hrdata_i(hrdata),
      .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
      .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic ck(input int s, input logic [31:0] v);
      @(negedge mclk);
      exp_q.push_back('{s, v});
      -> chk_ev;
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [31:0] m,
         input logic [31:0] v);
      host_u.rd(a, q);
      rd_last = q & m;
      ck(4, v);
   endtask
   function automatic logic [31:0] obs(input int s);
      case (s)
         0: obs = {30'h0, drive};
         1: obs = {30'h0, mode};
         2: obs = {31'h0, nm};
         3: obs = {31'h0, fs_oe};
         4: obs = rd_last;
         5: obs = {31'h0, (cnt >= 1000 && cnt <= 1048)};
         default: obs = {31'h0, ready};
      endcase
   endfunction
   initial forever begin
      smc_exp_t e;
      @(chk_ev);
      while (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         checks_done++;
         if (obs(e.sel) !== e.v) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nms[e.sel], e.v,
               obs(e.sel));
         end
      end
   end
   task automatic test_done();
      // let the monitor take the last note first
      cyc(1);
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic reset_all();
      @(posedge mclk) sys_rst <= 1'b1;
      rst_pin <= 1'b0;
      lsf <= 1'b0;
      cyc(2);
      sys_rst <= 1'b0;
   endtask
   // raise reset pin, then write control until ready, at most 100 tries
   task automatic wake_pin();
      @(posedge mclk) rst_pin <= 1'b1;
      for (int k = 0; k < 100 && ready !== 1'b1; k++) begin
         host_u.wr(OFS_CTRL, 32'h0);
         cyc(40);
      end
   endtask
   initial begin
      cyc(20000);
      error_cnt++;
      test_done();
   end
   initial begin
      void'($urandom(32'he3cc));
      reset_all();
      ck(1, 32'(SMC_SLEEP));
      ck(3, 32'h1);
      dv = 2'(1 + $urandom % 3);
      @(posedge mclk) dir_in <= dv;
      cyc(4);
      ck(1, 32'(SMC_NORMAL));
      ck(2, 32'h1);
      ck(0, 32'(dv));
      ck(6, 32'h0);
      @(posedge mclk) dir_in <= 2'h0;
      cyc(INC / 2);
      ck(1, 32'(SMC_NORMAL));
      cyc(INC);
      ck(1, 32'(SMC_SLEEP));
      ck(0, 32'h0);
      $display("test direct_wake done");
      wake_pin();
      ck(6, 32'h1);
      host_u.wr(OFS_CTRL, 32'h1);
      rdchk(OFS_CTRL, 32'h7, 32'h1);
      rdchk(OFS_STATE, 32'h7c, 32'h54);
      rdchk(6'h28, 32'hffffffff, 32'h0);
      for (int i = 0; i < 5; i++) begin
         c = $urandom % 2;
         host_u.wr(OFS_CFG0, c ? 32'h0 : 32'(tbl[i][9:0]));
         host_u.wr(OFS_CFG1, c ? 32'(tbl[i][9:0]) : 32'h0);
         @(posedge mclk) dir_in <= 2'(tbl[i][10]) << c;
         cyc(6);
         ck(0, 32'(2'(tbl[i][11]) << c));
      end
      host_u.wr(OFS_CFG1, 32'h0);
      host_u.wr(OFS_PW0, 32'h80);
      host_u.wr(OFS_CFG0, 32'hb);
      @(posedge mclk) dir_in <= 2'h0;
      cyc(8);
      for (int k = 0; k < 2048; k++) begin
         @(posedge mclk);
         if (k % 2 == 0) ext_clk <= ~ext_clk;
         cnt += int'(drive[0] === 1'b1);
      end
      ck(5, 32'h1);
      $display("test drive_target done");
      host_u.wr(OFS_CFG0, 32'h1);
      for (int i = 0; i < 4; i++) begin
         c = $urandom % 2;
         @(posedge mclk);
         oc <= 2'(i == 0) << c;
         ot <= 2'(i == 1) << c;
         sc <= 2'(i == 2) << c;
         uv <= (i == 3);
         cyc(4);
         ck(1, 32'(SMC_FAULT));
         ck(0, 32'h0);
         ck(2, 32'h0);
         @(posedge mclk) {oc, ot, sc, uv} <= 7'h0;
         cyc(4);
         ck(1, 32'(SMC_NORMAL));
      end
      @(posedge mclk) ov <= 1'b1;
      cyc(4);
      ck(1, 32'(SMC_NORMAL));
      host_u.wr(OFS_CTRL, 32'h5);
      cyc(4);
      ck(1, 32'(SMC_FAULT));
      @(posedge mclk) ov <= 1'b0;
      host_u.wr(OFS_CTRL, 32'h3);
      cyc(WDC + 50);
      ck(1, 32'(SMC_NORMAL));
      dv = 2'($urandom % 4);
      @(posedge mclk) dir_in <= dv;
      lsf <= 1'b1;
      cyc(4);
      ck(1, 32'(SMC_FAILSAFE));
      ck(3, 32'h0);
      ck(0, 32'(dv));
      rdchk(OFS_CFG0, 32'hffffffff, 32'h0);
      $display("test faults done");
      reset_all();
      wake_pin();
      host_u.wr(OFS_CTRL, 32'h0);
      cyc(150);
      ck(1, 32'(SMC_NORMAL));
      cyc(100);
      ck(1, 32'(SMC_FAILSAFE));
      ck(3, 32'h0);
      $display("test watchdog done");
      test_done();
   end
endmodule // switch_mode_and_channel_control_tb_top
`default_nettype wire
